// [rtl/i2c_port_consts.svh]
`ifndef I2C_PORT_CONSTS_SVH
`define I2C_PORT_CONSTS_SVH
// slave address, upper six bits; strap gives the last
`define DEV_ADDR_HI   6'h15
// glitch filter setting register and its enable bit
`define FILT_REG      7'h66
`define FILT_EN_BIT   0
`define FILT_NS       50
`define CLK_NS        10
`define FILT_CYC      4'((`FILT_NS + `CLK_NS - 1) / `CLK_NS)
// coefficient space and filter-section ranges
`define COEF_N        102
`define COEF_LAST     7'h65
`define BQ_A_END      7'h31
`define BQ_B_START    7'h5C
`define BQ_LEN        7'h05
`define BQ_LASTPOS    3'h4
`define BYTE_BITS     4'h8
`define LAST_BYTE     2'h3
// register bus map
`define A_CTRL        8'h00
`define A_STAT        8'h04
`define A_PTR         8'h08
`define A_DATA        8'h0C
`define RESP_OK       2'h0
`define RESP_DEC      2'h3
`endif

// [rtl/i2c_port_pkg.sv]
package i2c_port_pkg;
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_ADDR = 4'h1,
        S_AACK = 4'h2,
        S_SUB  = 4'h3,
        S_SACK = 4'h4,
        S_WDAT = 4'h5,
        S_WACK = 4'h6,
        S_RDAT = 4'h7,
        S_RACK = 4'h8,
        S_IGN  = 4'h9
    } state_t;
    typedef struct packed {
        logic scl;
        logic sda;
    } lines_t;
endpackage

// [rtl/i2c_slave_register_port.sv]
// Functional notes
// - sda is only pulled low or released, never driven high
// - slave only; scl is always taken from the host
// - sda fall with scl high is start, sda rise is stop
// - every stop returns the protocol machine to idle
// - bytes go msb first, lsb in eighth slot, then ack slot
// - slave pulls sda low in ninth slot after each written byte
// - in reads slave releases sda in ninth slot and samples host ack
// - address 0101010 if strap low at reset release, else 0101011
// - eighth bit of first byte: low write, high read
// - second write byte is register address, next byte is stored
// - without auto-increment, address/data pairs repeat until stop
// - msb of address byte set: successive addresses, wrapping
// - coefficient registers are four bytes, most significant first
// - filter-section words held, all five committed on the fifth
// - read: start, write address, register, restart, read address
// - auto-increment read advances address while host acks
// - coefficient reads return four bytes msb first
// - glitch filter on scl and sda enabled by register 0x66
// - active-low reset; address strap sampled at its release
`include "i2c_port_consts.svh"
module i2c_slave_register_port (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        adSel,
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOeN,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);
    i2c_port_pkg::state_t state_q;
    i2c_port_pkg::lines_t sync1_q;
    i2c_port_pkg::lines_t sync2_q;
    i2c_port_pkg::lines_t sync3_q;
    i2c_port_pkg::lines_t qual_q;
    i2c_port_pkg::lines_t filt_q;
    i2c_port_pkg::lines_t prev_q;
    logic [3:0]  fcnt_q [2];
    logic [7:0]  sysMem_q [128];
    logic [31:0] coefMem_q [`COEF_N];
    logic [31:0] stage_q [5];
    logic [31:0] stageNext [5];
    logic        strapTaken_q;
    logic        adSel_q;
    logic [3:0]  bitCnt_q;
    logic [7:0]  shift_q;
    logic [7:0]  txShift_q;
    logic        rw_q;
    logic [6:0]  regAddr_q;
    logic        aif_q;
    logic [1:0]  byteIdx_q;
    logic [23:0] wordAcc_q;
    logic        nextSub_q;
    logic        hostAck_q;
    logic        drvLow_q;
    logic        coefMode_q;
    logic [7:0]  ptr_q;
    logic        awHave_q;
    logic        wHave_q;
    logic [7:0]  awAddr_q;
    logic [31:0] wData_q;
    logic        wStrb0_q;

    // edges and conditions from the filtered lines
    wire logic sclRise  = filt_q.scl & ~prev_q.scl;
    wire logic sclFall  = ~filt_q.scl & prev_q.scl;
    wire logic startDet = prev_q.scl & filt_q.scl
                          & prev_q.sda & ~filt_q.sda;
    wire logic stopDet  = prev_q.scl & filt_q.scl
                          & ~prev_q.sda & filt_q.sda;
    wire logic byteEnd  = sclFall & (bitCnt_q == `BYTE_BITS);
    wire logic filtOn   = sysMem_q[`FILT_REG][`FILT_EN_BIT];
    wire logic [6:0] myAddr = {`DEV_ADDR_HI, adSel_q};
    wire logic addrHit  = shift_q[7:1] == myAddr;

    // four-byte access and filter-section decode
    wire logic isQuad = coefMode_q & (regAddr_q <= `COEF_LAST);
    wire logic inBqA  = regAddr_q <= `BQ_A_END;
    wire logic inBq   = isQuad & (inBqA | (regAddr_q >= `BQ_B_START));
    wire logic [6:0] bqOff = inBqA ? regAddr_q
                                   : 7'(regAddr_q - `BQ_B_START);
    wire logic [2:0] bqPos = 3'(bqOff % `BQ_LEN);
    wire logic [6:0] bqBase = 7'(regAddr_q - 7'(bqPos));

    // write events of the data phase
    wire logic wrEvt   = byteEnd & (state_q == i2c_port_pkg::S_WDAT);
    wire logic sysWe   = wrEvt & ~isQuad;
    wire logic coefWe  = wrEvt & isQuad & (byteIdx_q == `LAST_BYTE);
    wire logic [31:0] wordIn = {wordAcc_q, shift_q};
    wire logic commit  = coefWe & inBq & (bqPos == `BQ_LASTPOS);
    wire logic unitDone = ~isQuad | (byteIdx_q == `LAST_BYTE);

    // byte presented to the host on reads
    wire logic [31:0] coefRd = isQuad ? coefMem_q[regAddr_q] : 32'h0;
    wire logic [7:0] rdByte =
        ~isQuad               ? sysMem_q[regAddr_q] :
        (byteIdx_q == 2'h0)   ? coefRd[31:24] :
        (byteIdx_q == 2'h1)   ? coefRd[23:16] :
        (byteIdx_q == 2'h2)   ? coefRd[15:8]  : coefRd[7:0];

    // bus-side peek decode
    wire logic ptrCoef = ptr_q[7] & (ptr_q[6:0] <= `COEF_LAST);
    wire logic [31:0] peek =
        ptrCoef  ? coefMem_q[ptr_q[6:0]] :
        ptr_q[7] ? 32'h0 : {24'h0, sysMem_q[ptr_q[6:0]]};
    wire logic [31:0] status = {16'h0, 1'b0, regAddr_q,
                                4'h0, strapTaken_q, adSel_q,
                                coefMode_q,
                                state_q != i2c_port_pkg::S_IDLE};
    wire logic wrGo   = awHave_q & wHave_q & ~bvalid;
    wire logic arTake = arvalid & arready;

    // open-drain pin: low or released only
    assign sdaOut  = 1'b0;
    assign sdaOeN  = ~drvLow_q;
    assign awready = ~awHave_q;
    assign wready  = ~wHave_q;
    assign arready = ~rvalid;

    // strap caught once, first enabled edge after reset release
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            strapTaken_q <= 1'b0;
            adSel_q      <= 1'b0;
        end else if (ce && !strapTaken_q) begin
            strapTaken_q <= 1'b1;
            adSel_q      <= adSel;
        end
    end

    // three-stage synchroniser, level taken when stages 2 and 3 agree
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= '1;
            sync2_q <= '1;
            sync3_q <= '1;
            qual_q  <= '1;
        end else if (ce) begin
            sync1_q <= {sclIn, sdaIn};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (sync2_q.scl == sync3_q.scl)
                qual_q.scl <= sync3_q.scl;
            if (sync2_q.sda == sync3_q.sda)
                qual_q.sda <= sync3_q.sda;
        end
    end

    // glitch filter per line: change only after it has stood long enough
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gFilt
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    fcnt_q[g] <= 4'h0;
                    filt_q[g] <= 1'b1;
                end else if (ce) begin
                    if (qual_q[g] == filt_q[g]) begin
                        fcnt_q[g] <= 4'h0;
                    end else if (!filtOn
                                 || fcnt_q[g] == `FILT_CYC) begin
                        filt_q[g] <= qual_q[g];
                        fcnt_q[g] <= 4'h0;
                    end else begin
                        fcnt_q[g] <= 4'(fcnt_q[g] + 4'h1);
                    end
                end
            end
        end
    endgenerate

    // previous filtered levels for edge finding
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            prev_q <= '1;
        else if (ce)
            prev_q <= filt_q;
    end

    // protocol machine
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q   <= i2c_port_pkg::S_IDLE;
            bitCnt_q  <= 4'h0;
            shift_q   <= 8'h0;
            txShift_q <= 8'h0;
            rw_q      <= 1'b0;
            drvLow_q  <= 1'b0;
            hostAck_q <= 1'b0;
        end else if (ce) begin
            if (stopDet) begin
                state_q  <= i2c_port_pkg::S_IDLE;
                drvLow_q <= 1'b0;
            end else if (startDet) begin
                state_q  <= i2c_port_pkg::S_ADDR;
                bitCnt_q <= 4'h0;
                drvLow_q <= 1'b0;
            end else if (sclRise) begin
                case (state_q)
                    i2c_port_pkg::S_ADDR,
                    i2c_port_pkg::S_SUB,
                    i2c_port_pkg::S_WDAT: begin
                        shift_q  <= {shift_q[6:0], filt_q.sda};
                        bitCnt_q <= 4'(bitCnt_q + 4'h1);
                    end
                    i2c_port_pkg::S_RDAT:
                        bitCnt_q <= 4'(bitCnt_q + 4'h1);
                    i2c_port_pkg::S_RACK:
                        hostAck_q <= ~filt_q.sda;
                    default: ;
                endcase
            end else if (sclFall) begin
                case (state_q)
                    i2c_port_pkg::S_ADDR: begin
                        if (byteEnd && addrHit) begin
                            state_q  <= i2c_port_pkg::S_AACK;
                            drvLow_q <= 1'b1;
                            rw_q     <= shift_q[0];
                        end else if (byteEnd) begin
                            state_q  <= i2c_port_pkg::S_IGN;
                        end
                    end
                    i2c_port_pkg::S_AACK: begin
                        bitCnt_q <= 4'h0;
                        if (rw_q) begin
                            state_q   <= i2c_port_pkg::S_RDAT;
                            txShift_q <= rdByte;
                            drvLow_q  <= ~rdByte[7];
                        end else begin
                            state_q  <= i2c_port_pkg::S_SUB;
                            drvLow_q <= 1'b0;
                        end
                    end
                    i2c_port_pkg::S_SUB: begin
                        if (byteEnd) begin
                            state_q  <= i2c_port_pkg::S_SACK;
                            drvLow_q <= 1'b1;
                        end
                    end
                    i2c_port_pkg::S_WDAT: begin
                        if (byteEnd) begin
                            state_q  <= i2c_port_pkg::S_WACK;
                            drvLow_q <= 1'b1;
                        end
                    end
                    i2c_port_pkg::S_SACK: begin
                        state_q  <= i2c_port_pkg::S_WDAT;
                        bitCnt_q <= 4'h0;
                        drvLow_q <= 1'b0;
                    end
                    i2c_port_pkg::S_WACK: begin
                        bitCnt_q <= 4'h0;
                        drvLow_q <= 1'b0;
                        state_q  <= nextSub_q
                                    ? i2c_port_pkg::S_SUB
                                    : i2c_port_pkg::S_WDAT;
                    end
                    i2c_port_pkg::S_RDAT: begin
                        if (byteEnd) begin
                            state_q  <= i2c_port_pkg::S_RACK;
                            drvLow_q <= 1'b0;
                        end else begin
                            txShift_q <= {txShift_q[6:0], 1'b0};
                            drvLow_q  <= ~txShift_q[6];
                        end
                    end
                    i2c_port_pkg::S_RACK: begin
                        bitCnt_q <= 4'h0;
                        if (hostAck_q) begin
                            state_q   <= i2c_port_pkg::S_RDAT;
                            txShift_q <= rdByte;
                            drvLow_q  <= ~rdByte[7];
                        end else begin
                            state_q   <= i2c_port_pkg::S_IGN;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // register pointer, byte position and word assembly
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            regAddr_q <= 7'h0;
            aif_q     <= 1'b0;
            byteIdx_q <= 2'h0;
            wordAcc_q <= 24'h0;
            nextSub_q <= 1'b0;
        end else if (ce) begin
            if (byteEnd && state_q == i2c_port_pkg::S_SUB) begin
                regAddr_q <= shift_q[6:0];
                aif_q     <= shift_q[7];
                byteIdx_q <= 2'h0;
            end else if (wrEvt) begin
                nextSub_q <= unitDone & ~aif_q;
                wordAcc_q <= {wordAcc_q[15:0], shift_q};
                byteIdx_q <= unitDone ? 2'h0
                                      : 2'(byteIdx_q + 2'h1);
                if (unitDone && aif_q)
                    regAddr_q <= 7'(regAddr_q + 7'h1);
            end else if (sclRise && state_q == i2c_port_pkg::S_RACK
                         && !filt_q.sda) begin
                byteIdx_q <= unitDone ? 2'h0
                                      : 2'(byteIdx_q + 2'h1);
                if (unitDone && aif_q)
                    regAddr_q <= 7'(regAddr_q + 7'h1);
            end else if (startDet) begin
                byteIdx_q <= 2'h0;
            end
        end
    end

    // single-byte register store
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 128; i++)
                sysMem_q[i] <= 8'h0;
        end else if (ce && sysWe) begin
            sysMem_q[regAddr_q] <= shift_q;
        end
    end

    // staging for filter sections, final word bypasses the stage
    always_comb begin
        for (int k = 0; k < 5; k++)
            stageNext[k] = (3'(k) == `BQ_LASTPOS) ? wordIn : stage_q[k];
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int k = 0; k < 5; k++)
                stage_q[k] <= 32'h0;
        end else if (ce && coefWe && inBq) begin
            stage_q[bqPos] <= wordIn;
        end
    end

    // coefficient store, one entry per index
    genvar c;
    generate
        for (c = 0; c < `COEF_N; c++) begin : gCoef
            localparam logic [6:0] IDX = 7'(c);
            wire logic [6:0] off = 7'(IDX - bqBase);
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn)
                    coefMem_q[c] <= 32'h0;
                else if (ce && commit && IDX >= bqBase
                         && IDX <= regAddr_q)
                    coefMem_q[c] <= stageNext[off[2:0]];
                else if (ce && coefWe && !inBq && regAddr_q == IDX)
                    coefMem_q[c] <= wordIn;
            end
        end
    endgenerate

    // register bus: write address and data taken in either order
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            awHave_q   <= 1'b0;
            wHave_q    <= 1'b0;
            awAddr_q   <= 8'h0;
            wData_q    <= 32'h0;
            wStrb0_q   <= 1'b0;
            bvalid     <= 1'b0;
            bresp      <= `RESP_OK;
            coefMode_q <= 1'b0;
            ptr_q      <= 8'h0;
        end else if (ce) begin
            if (awvalid && !awHave_q) begin
                awHave_q <= 1'b1;
                awAddr_q <= awaddr;
            end
            if (wvalid && !wHave_q) begin
                wHave_q <= 1'b1;
                wData_q <= wdata;
                wStrb0_q <= wstrb[0];
            end
            if (wrGo) begin
                awHave_q <= 1'b0;
                wHave_q  <= 1'b0;
                bvalid   <= 1'b1;
                bresp    <= `RESP_OK;
                if (awAddr_q == `A_CTRL && wStrb0_q)
                    coefMode_q <= wData_q[0];
                else if (awAddr_q == `A_PTR && wStrb0_q)
                    ptr_q <= wData_q[7:0];
                else if (awAddr_q != `A_CTRL && awAddr_q != `A_PTR)
                    bresp <= `RESP_DEC;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // register bus: read channel
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= `RESP_OK;
        end else if (ce) begin
            if (arTake) begin
                rvalid <= 1'b1;
                rresp  <= `RESP_OK;
                case (araddr)
                    `A_CTRL: rdata <= {31'h0, coefMode_q};
                    `A_STAT: rdata <= status;
                    `A_PTR:  rdata <= {24'h0, ptr_q};
                    `A_DATA: rdata <= peek;
                    default: begin
                        rdata <= 32'h0;
                        rresp <= `RESP_DEC;
                    end
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_addrMatch;
        ce && state_q == i2c_port_pkg::S_ADDR && byteEnd
        && !stopDet && !startDet && addrHit;
    endsequence

    sequence s_ackDriven;
        state_q == i2c_port_pkg::S_AACK && !sdaOeN;
    endsequence

    chk_stop_to_idle: assert property (
        ce && stopDet |=> state_q == i2c_port_pkg::S_IDLE)
        else $error("stop did not return machine to idle");

    chk_start_to_addr: assert property (
        ce && startDet && !stopDet |=> state_q == i2c_port_pkg::S_ADDR
        && sdaOeN)
        else $error("start not taken into address phase");

    chk_addr_ack: assert property (
        s_addrMatch |=> s_ackDriven)
        else $error("matching address not acknowledged");

    chk_miss_ignored: assert property (
        ce && state_q == i2c_port_pkg::S_ADDR && byteEnd && !addrHit
        && !stopDet && !startDet
        |=> state_q == i2c_port_pkg::S_IGN && sdaOeN)
        else $error("unmatched address not ignored");

    chk_write_ack: assert property (
        (state_q == i2c_port_pkg::S_WACK
         || state_q == i2c_port_pkg::S_SACK) |-> !sdaOeN)
        else $error("write byte not acknowledged");

    chk_read_release: assert property (
        state_q == i2c_port_pkg::S_RACK |-> sdaOeN)
        else $error("sda held during host ack slot");

    chk_drive_states: assert property (
        !sdaOeN |-> state_q inside {i2c_port_pkg::S_AACK,
        i2c_port_pkg::S_SACK, i2c_port_pkg::S_WACK,
        i2c_port_pkg::S_RDAT})
        else $error("sda pulled low outside a driving slot");

    chk_strap_addr: assert property (
        strapTaken_q && $stable(strapTaken_q) |-> $stable(adSel_q))
        else $error("address strap changed after capture");

    chk_commit_fifth: assert property (
        ce && commit |=> coefMem_q[$past(regAddr_q)] == $past(wordIn))
        else $error("fifth coefficient not committed");

    chk_aif_step: assert property (
        ce && wrEvt && unitDone && aif_q && !stopDet && !startDet
        |=> regAddr_q == 7'($past(regAddr_q) + 7'h1))
        else $error("auto-increment did not advance");
endmodule

// [verification/i2c_host_model.sv]
// host side of the serial port; sda is only pulled low or released
module i2c_host_model (
    output logic      scl,
    output logic      sdaRel,
    input  wire logic sdaLine
);
    timeunit 1ns;
    timeprecision 100ps;
    // half period of the 125 ns link clock
    localparam realtime HALF = 62.5;
    // both lines idle released high
    initial begin
        scl = 1'b1;
        sdaRel = 1'b1;
    end
    // start or repeated start: sda falls with scl high
    task automatic start();
        sdaRel = 1'b1;
        #HALF scl = 1'b1;
        #HALF sdaRel = 1'b0;
        #HALF scl = 1'b0;
    endtask
    // stop: sda rises with scl high
    task automatic stop();
        sdaRel = 1'b0;
        #HALF scl = 1'b1;
        #HALF sdaRel = 1'b1;
        #HALF;
    endtask
    // msb first, then the ack slot; sda moves only while scl is low
    task automatic xfer(input logic [7:0] tx, input logic ack,
                        output logic [7:0] rx, output logic slot9);
        logic [8:0] bits;
        logic [8:0] got;
        bits = {tx, ~ack};
        for (int i = 8; i >= 0; i--) begin
            sdaRel = bits[i];
            #HALF scl = 1'b1;
            #(HALF/2) got[i] = sdaLine;
            #(HALF/2) scl = 1'b0;
        end
        sdaRel = 1'b1;
        rx = got[8:1];
        slot9 = got[0];
    endtask
endmodule

// [verification/i2c_slave_register_port_tb_top.sv]
module i2c_slave_register_port_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk = 1'b0, resetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        sdaOut, sdaOeN, scl, sdaRel;
    logic [1:0]  bresp, rresp;
    logic [31:0] d;
    logic [7:0]  rx;
    logic        s9;
    logic [1:0]  r;
    logic        adSel = 1'b0;
    int          failures = 0, n_compared = 0, cyc = 0;
    // wired-and with pull-up
    wire sdaLine = sdaRel & (sdaOeN | sdaOut);
    i2c_slave_register_port DUT (.core_clk, .resetn, .ce(1'b1),
        .adSel, .sclIn(scl), .sdaIn(sdaLine), .sdaOut, .sdaOeN,
        .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready);
    i2c_host_model host (.scl(scl), .sdaRel(sdaRel), .sdaLine(sdaLine));
    // clock
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // register bus write: hold each channel until taken
    task automatic axw(input logic [7:0] a, input logic [31:0] v,
                       output logic [1:0] rs);
        logic aw, w, b;
        @(posedge core_clk);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge core_clk);
            aw = awvalid & awready; w = wvalid & wready; b = bvalid;
            rs = bresp;
            @(posedge core_clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end while (b !== 1'b1);
        bready <= 1'b0;
    endtask
    // register bus read
    task automatic axr(input logic [7:0] a, output logic [31:0] v,
                       output logic [1:0] rs);
        logic ar, rv;
        @(posedge core_clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(negedge core_clk);
            ar = arvalid & arready; rv = rvalid; v = rdata; rs = rresp;
            @(posedge core_clk);
            if (ar) arvalid <= 1'b0;
        end while (rv !== 1'b1);
        rready <= 1'b0;
    endtask
    // two address/data pairs in one transfer, then bus readback
    task automatic t_write();
        logic [7:0] seq [5] = '{8'h54, 8'h10, 8'hAB, 8'h11, 8'hCD};
        host.start();
        foreach (seq[i]) begin
            host.xfer(seq[i], 1'b0, rx, s9);
            chk(32'(s9), 32'h0);
        end
        host.stop();
        axw(8'h08, 32'h11, r);
        axr(8'h0C, d, r);
        chk(d, 32'hCD);
        axr(8'h04, d, r);
        chk(32'(d[0]), 32'h0);
        $display("test write done");
    endtask
    // restart read with auto increment, ack then no-ack
    task automatic t_read();
        host.start();
        host.xfer(8'h54, 1'b0, rx, s9);
        host.xfer(8'h90, 1'b0, rx, s9);
        host.start();
        host.xfer(8'h55, 1'b0, rx, s9);
        chk(32'(s9), 32'h0);
        host.xfer(8'hFF, 1'b1, rx, s9);
        chk(32'(rx), 32'hAB);
        host.xfer(8'hFF, 1'b0, rx, s9);
        chk(32'(rx), 32'hCD);
        host.stop();
        $display("test read done");
    endtask
    // other address ignored; stop mid-transfer; unmapped bus address
    task automatic t_misc();
        host.start();
        host.xfer(8'h56, 1'b0, rx, s9);
        chk(32'(s9), 32'h1);
        host.stop();
        host.start();
        host.xfer(8'h54, 1'b0, rx, s9);
        host.stop();
        axr(8'h04, d, r);
        chk(32'(d[0]), 32'h0);
        axr(8'h40, d, r);
        chk(32'(r), 32'h3);
        axw(8'h40, 32'h0, r);
        chk(32'(r), 32'h3);
        $display("test misc done");
    endtask
    // coefficient mode: section words held, committed on the fifth
    task automatic t_coef();
        axw(8'h00, 32'h1, r);
        host.start();
        host.xfer(8'h54, 1'b0, rx, s9);
        host.xfer(8'h80, 1'b0, rx, s9);
        for (int k = 0; k < 16; k++) begin
            host.xfer(8'(8'h10 + k), 1'b0, rx, s9);
            chk(32'(s9), 32'h0);
        end
        host.stop();
        axw(8'h08, 32'h80, r);
        axr(8'h0C, d, r);
        chk(d, 32'h0);
        host.start();
        host.xfer(8'h54, 1'b0, rx, s9);
        host.xfer(8'h04, 1'b0, rx, s9);
        for (int k = 0; k < 4; k++)
            host.xfer(8'(8'hA0 + k), 1'b0, rx, s9);
        host.stop();
        axr(8'h0C, d, r);
        chk(d, 32'h10111213);
        axw(8'h08, 32'h84, r);
        axr(8'h0C, d, r);
        chk(d, 32'hA0A1A2A3);
        host.start();
        host.xfer(8'h54, 1'b0, rx, s9);
        host.xfer(8'h03, 1'b0, rx, s9);
        host.start();
        host.xfer(8'h55, 1'b0, rx, s9);
        for (int k = 0; k < 4; k++) begin
            host.xfer(8'hFF, k != 3, rx, s9);
            chk(32'(rx), 32'(8'h1C + k));
        end
        host.stop();
        $display("test coef done");
    endtask
    // mid-run reset with the strap high moves the slave address
    task automatic t_strap();
        @(posedge core_clk);
        resetn <= 1'b0;
        adSel <= 1'b1;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        host.start();
        host.xfer(8'h54, 1'b0, rx, s9);
        chk(32'(s9), 32'h1);
        host.stop();
        host.start();
        host.xfer(8'h56, 1'b0, rx, s9);
        chk(32'(s9), 32'h0);
        host.stop();
        axr(8'h04, d, r);
        chk(32'(d[3:0]), 32'hC);
        $display("test strap done");
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // cycle ceiling against hangs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            report_and_stop();
        end
    end
    // main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_write();
        t_read();
        t_misc();
        t_coef();
        t_strap();
        report_and_stop();
    end
endmodule
